/* File: shared/crb_pkg.sv */
// Constants, types and position maps for the configurable registered buffer.
// Assumes one 100 MHz system clock whose rising edge is the differential clock crossing.
package crb_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int CRB_WIDE_BITS = 25;
    localparam int CRB_NARROW_BITS = 14;
    localparam int CRB_SYNC_BITS = 3;

    // ------------------------------------------------------------------
    // Positions (bit k holds input or output position k+1)
    // ------------------------------------------------------------------
    localparam logic [24:0] CRB_CTRL_MASK_WIDE = 25'h0000049;
    localparam logic [13:0] CRB_CTRL_MASK_A = 14'h0049;
    localparam logic [13:0] CRB_CTRL_MASK_B = 14'h2440;
    localparam int CRB_WIDE_CKE_POS = 0;
    localparam int CRB_WIDE_ODT_POS = 3;
    localparam int CRB_A_CKE_POS = 0;
    localparam int CRB_A_ODT_POS = 3;
    localparam int CRB_B_CKE_POS = 13;
    localparam int CRB_B_ODT_POS = 10;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [24:0] CRB_RST_WIDE = 25'h0000000;
    localparam logic [13:0] CRB_RST_NARROW = 14'h0000;
    localparam logic [1:0] CRB_RST_PAIR = 2'h0;
    localparam logic [CRB_SYNC_BITS-1:0] CRB_RST_SYNC = 3'h0;
    localparam int CRB_CLK_PERIOD_NS = 10;
    localparam int CRB_RX_SETTLE_NS = 50;
    localparam int CRB_RX_SETTLE_CYCLES =
        (CRB_RX_SETTLE_NS + CRB_CLK_PERIOD_NS - 1) / CRB_CLK_PERIOD_NS;
    localparam logic [3:0] CRB_RX_SETTLE_LAST = 4'(CRB_RX_SETTLE_CYCLES - 1);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CRB_RX_OFF = 2'h0,
        CRB_RX_WAKE = 2'h1,
        CRB_RX_ON = 2'h3
    } crb_rx_state_t;

endpackage

/* File: shared/crb_route_if.sv */
// Interface between the buffer top and its position mapper.
// Assumes the mapper is purely combinational.
`timescale 1ns/10ps
`default_nettype none
interface crb_route_if;
    import crb_pkg::*;
    logic fanout_mode;                 // High selects duplicated mode
    logic pinout_variant;              // High selects variant B
    logic [24:0] data_in;              // Data positions straight off the pins
    logic [24:0] wide_out;             // Next one-to-one or copy A image
    logic [13:0] narrow_out;           // Next copy B image
    logic [1:0] cke_out;               // Next clock-enable pair
    logic [1:0] odt_out;               // Next termination pair

    modport top (output fanout_mode, pinout_variant, data_in,
                 input wide_out, narrow_out, cke_out, odt_out);
    modport mapper (input fanout_mode, pinout_variant, data_in,
                    output wide_out, narrow_out, cke_out, odt_out);
endinterface
`default_nettype wire

/* File: logic/crb_pin_sync.sv */
// Two-stage synchroniser for static pins and the reset pin release.
// Assumes i_clr_n is the asynchronous reset pin; flops clear to zero on it.
`timescale 1ns/10ps
`default_nettype none
module crb_pin_sync
    import crb_pkg::*;
(
    input wire logic i_clk_sys,                      // System clock
    input wire logic i_sys_rst,                      // Synchronous reset
    input wire logic i_clr_n,                        // Asynchronous clear, low
    input wire logic [CRB_SYNC_BITS-1:0] i_pin,      // Pin levels
    output logic [CRB_SYNC_BITS-1:0] o_pin           // Synchronised levels
);
    logic [CRB_SYNC_BITS-1:0] stage1;
    logic [CRB_SYNC_BITS-1:0] stage2;
    logic [CRB_SYNC_BITS-1:0] next_stage1;
    logic [CRB_SYNC_BITS-1:0] next_stage2;

    // Next values; first stage feeds only the second
    always_comb begin
        next_stage1 = i_sys_rst ? CRB_RST_SYNC : i_pin;
        next_stage2 = i_sys_rst ? CRB_RST_SYNC : stage1;
    end

    // Assert at once on the pin, release on the clock
    always_ff @(posedge i_clk_sys or negedge i_clr_n) begin
        if (!i_clr_n) begin
            stage1 <= CRB_RST_SYNC;
            stage2 <= CRB_RST_SYNC;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign o_pin = stage2;
endmodule
`default_nettype wire

/* File: logic/crb_pos_map.sv */
// Position mapper: routes the data inputs straight off the pins onto output images per mode.
// Assumes configuration is static while outputs are active.
`timescale 1ns/10ps
`default_nettype none
module crb_pos_map
    import crb_pkg::*;
(
    crb_route_if.mapper rt                          // Mapping request and result
);
    // ------------------------------------------------------------------
    // Per-position routing
    // ------------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < CRB_WIDE_BITS; k = k + 1) begin : g_pos
            if (k < CRB_NARROW_BITS) begin : g_dual
                // Copies A and B from one input; control slots carry no data
                always_comb begin
                    if (rt.fanout_mode) begin
                        rt.wide_out[k] = rt.data_in[k] &
                            ~(rt.pinout_variant ? CRB_CTRL_MASK_B[k] : CRB_CTRL_MASK_A[k]);
                        rt.narrow_out[k] = rt.wide_out[k];
                    end else begin
                        rt.wide_out[k] = rt.data_in[k] & ~CRB_CTRL_MASK_WIDE[k];
                        rt.narrow_out[k] = 1'b0;
                    end
                end
            end else begin : g_wide
                // Upper positions exist only in one-to-one mode
                always_comb begin
                    rt.wide_out[k] = rt.fanout_mode ? 1'b0 : rt.data_in[k];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Clock-enable and termination pairs
    // ------------------------------------------------------------------
    always_comb begin
        rt.cke_out = {rt.fanout_mode, 1'b1} & {2{1'b1}};
        rt.odt_out = rt.cke_out;
    end
endmodule
`default_nettype wire

/* File: logic/crb_buffer_top.sv */
// Configurable registered buffer: 25-bit one-to-one or 14-bit one-to-two.
// Assumes data and rank selects are driven on the system clock by the host,
// and that configuration and reset pins are asynchronous static levels.
`timescale 1ns/10ps
`default_nettype none
module crb_buffer_top
    import crb_pkg::*;
(
    input wire logic i_clk_sys,                          // Clock crossing
    input wire logic i_sys_rst,                          // Sync reset, high
    input wire logic i_reset_n,                          // Device reset pin, low
    input wire logic i_pinout_variant_select,            // Low A, high B
    input wire logic i_fanout_mode_select,               // Low 1:1, high 1:2
    input wire logic [24:0] i_buffered_inputs,           // Data positions 1..25
    input wire logic i_primary_rank_select_in,           // Primary select, low
    input wire logic i_secondary_rank_select_in,         // Secondary select, low
    input wire logic i_clock_enable_in,                  // Clock-enable input
    input wire logic i_termination_ctrl_in,              // Termination input
    output logic [24:0] o_registered_outputs,            // 1:1 outputs or copy A
    output logic [13:0] o_registered_outputs_b,          // Copy B outputs
    output logic [1:0] o_rank_select_out,                // Rank select {B,A}
    output logic [1:0] o_clock_enable_out,               // Clock enable {B,A}
    output logic [1:0] o_termination_ctrl_out,           // Termination {B,A}
    output logic o_receivers_enabled,                    // Inputs being taken
    output logic o_outputs_held                          // Gated outputs frozen
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [CRB_SYNC_BITS-1:0] pins_raw;
    logic [CRB_SYNC_BITS-1:0] pins_sync;
    logic reset_released;
    logic fanout_mode;
    logic pinout_variant;
    logic both_deselected;
    logic wide_active;

    crb_rx_state_t rx_state;
    crb_rx_state_t next_rx_state;
    logic [3:0] settle_cnt;
    logic [3:0] next_settle_cnt;

    logic [24:0] q_wide;
    logic [13:0] q_narrow;
    logic [1:0] q_cs;
    logic [1:0] q_cke;
    logic [1:0] q_odt;
    logic q_rx_en;
    logic q_held;
    logic [24:0] next_q_wide;
    logic [13:0] next_q_narrow;
    logic [1:0] next_q_cs;
    logic [1:0] next_q_cke;
    logic [1:0] next_q_odt;
    logic next_q_rx_en;
    logic next_q_held;

    crb_route_if rt ();

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------

    // Reset release and static configuration pass two flops
    assign pins_raw = {1'b1, i_pinout_variant_select, i_fanout_mode_select};

    crb_pin_sync u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_clr_n   (i_reset_n),
        .i_pin     (pins_raw),
        .o_pin     (pins_sync)
    );

    // Synchronised levels; config is static, so no capture is needed
    assign reset_released = pins_sync[2];
    assign pinout_variant = pins_sync[1];
    assign fanout_mode = pins_sync[0];

    // ------------------------------------------------------------------
    // Position mapping
    // ------------------------------------------------------------------

    // Mapper sees the data inputs straight off the pins; its result is captured on the clock crossing
    assign rt.fanout_mode = fanout_mode;
    assign rt.pinout_variant = pinout_variant;
    assign rt.data_in = i_buffered_inputs;

    crb_pos_map u_pos_map (
        .rt (rt)
    );

    // ------------------------------------------------------------------
    // Receiver enable sequencing
    // ------------------------------------------------------------------

    // Receivers come up over a settle time; outputs stay low meanwhile
    always_comb begin
        next_rx_state = rx_state;
        next_settle_cnt = settle_cnt;
        if (i_sys_rst || !reset_released) begin
            next_rx_state = CRB_RX_OFF;
            next_settle_cnt = 4'h0;
        end else begin
            unique case (rx_state)
                CRB_RX_OFF: begin
                    next_rx_state = CRB_RX_WAKE;
                    next_settle_cnt = 4'h0;
                end
                CRB_RX_WAKE: begin
                    if (settle_cnt == CRB_RX_SETTLE_LAST) begin
                        next_rx_state = CRB_RX_ON;
                    end else begin
                        next_settle_cnt = settle_cnt + 4'h1;
                    end
                end
                CRB_RX_ON: begin
                    next_rx_state = CRB_RX_ON;
                end
                default: begin
                    next_rx_state = CRB_RX_OFF;
                end
            endcase
        end
    end

    // Sequencer state; the reset pin drops it at once
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_state <= CRB_RX_OFF;
            settle_cnt <= 4'h0;
        end else begin
            rx_state <= next_rx_state;
            settle_cnt <= next_settle_cnt;
        end
    end

    // ------------------------------------------------------------------
    // Output register next values
    // ------------------------------------------------------------------

    // Freeze only when both selects are high at this edge
    assign both_deselected = i_primary_rank_select_in & i_secondary_rank_select_in;
    assign wide_active = (next_rx_state == CRB_RX_ON) && (rx_state == CRB_RX_ON);

    // Gated outputs hold; clock-enable and termination follow whenever receivers are on
    always_comb begin
        next_q_wide = q_wide;
        next_q_narrow = q_narrow;
        next_q_cs = q_cs;
        next_q_cke = CRB_RST_PAIR;
        next_q_odt = CRB_RST_PAIR;
        next_q_rx_en = wide_active;
        next_q_held = 1'b0;
        if (!wide_active) begin
            // Receivers off or waking: everything driven low
            next_q_wide = CRB_RST_WIDE;
            next_q_narrow = CRB_RST_NARROW;
            next_q_cs = CRB_RST_PAIR;
        end else begin
            if (both_deselected) begin
                next_q_held = 1'b1;
            end else begin
                next_q_wide = rt.wide_out;
                next_q_narrow = rt.narrow_out;
                next_q_cs = rt.cke_out & {2{i_primary_rank_select_in}};
            end
            // Never frozen by the rank selects
            next_q_cke = rt.cke_out & {2{i_clock_enable_in}};
            next_q_odt = rt.odt_out & {2{i_termination_ctrl_in}};
        end
    end

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------

    // Capture on the crossing; pin reset clears without a clock edge
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q_wide <= CRB_RST_WIDE;
            q_narrow <= CRB_RST_NARROW;
            q_cs <= CRB_RST_PAIR;
            q_cke <= CRB_RST_PAIR;
            q_odt <= CRB_RST_PAIR;
            q_rx_en <= 1'b0;
            q_held <= 1'b0;
        end else if (i_sys_rst) begin
            q_wide <= CRB_RST_WIDE;
            q_narrow <= CRB_RST_NARROW;
            q_cs <= CRB_RST_PAIR;
            q_cke <= CRB_RST_PAIR;
            q_odt <= CRB_RST_PAIR;
            q_rx_en <= 1'b0;
            q_held <= 1'b0;
        end else begin
            q_wide <= next_q_wide;
            q_narrow <= next_q_narrow;
            q_cs <= next_q_cs;
            q_cke <= next_q_cke;
            q_odt <= next_q_odt;
            q_rx_en <= next_q_rx_en;
            q_held <= next_q_held;
        end
    end

    // ------------------------------------------------------------------
    // Output assembly
    // ------------------------------------------------------------------

    // Control slots in the image are zero, so no mux on the output path
    assign o_registered_outputs = q_wide;
    assign o_registered_outputs_b = q_narrow;
    assign o_rank_select_out = q_cs;
    assign o_clock_enable_out = q_cke;
    assign o_termination_ctrl_out = q_odt;
    assign o_receivers_enabled = q_rx_en;
    assign o_outputs_held = q_held;

endmodule
`default_nettype wire

/* File: verif/crb_host_model.sv */
// Host controller model: drives the buffer's data, select and reset pins.
// Assumes the bench sets wanted levels just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module crb_host_model
(
    input wire logic i_clk_sys,       // System clock
    input wire logic i_req_reset_n,   // Wanted reset pin level
    input wire logic [28:0] i_req,    // Wanted {data, pri, sec, cke, odt}
    output logic o_reset_n,           // Device reset pin
    output logic [28:0] o_pins        // Driven {data, pri, sec, cke, odt}
);
    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    logic flip = 1'b0;
    // Released lines wander every cycle, so a capture during reset shows
    always @(posedge i_clk_sys) begin
        flip <= ~flip;
    end
    // Lines float in standby; a real host does not hold them
    assign o_reset_n = i_req_reset_n;
    assign o_pins = i_req_reset_n ? i_req : ({29{flip}} ^ 29'h0AAAAAAA);
endmodule
`default_nettype wire

/* File: verif/crb_buffer_checker.sv */
// Checker on the buffer top ports.
// Assumes configuration pins change only while the reset pin is low.
`timescale 1ns/10ps
`default_nettype none
module crb_buffer_checker
    import crb_pkg::*;
(
    input wire logic i_clk_sys,                  // Clock
    input wire logic i_sys_rst,                  // Sync reset
    input wire logic i_reset_n,                  // Reset pin
    input wire logic i_pinout_variant_select,    // Variant
    input wire logic i_fanout_mode_select,       // Mode
    input wire logic [24:0] i_buffered_inputs,   // Data
    input wire logic i_primary_rank_select_in,   // Primary select
    input wire logic i_secondary_rank_select_in, // Secondary select
    input wire logic i_clock_enable_in,          // Clock enable
    input wire logic i_termination_ctrl_in,      // Termination
    input wire logic [24:0] o_registered_outputs, // Copy A or 1:1
    input wire logic [13:0] o_registered_outputs_b, // Copy B
    input wire logic [1:0] o_rank_select_out,    // Rank select
    input wire logic [1:0] o_clock_enable_out,   // Clock enable
    input wire logic [1:0] o_termination_ctrl_out, // Termination
    input wire logic o_receivers_enabled,        // Captures live
    input wire logic o_outputs_held              // Frozen
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Reset pin in the guards: an async clear between edges wins
    wire logic live = o_receivers_enabled && i_reset_n;
    wire logic gated = i_primary_rank_select_in && i_secondary_rank_select_in;
    sequence s_quiet;
        {o_registered_outputs, o_registered_outputs_b, o_rank_select_out,
         o_clock_enable_out, o_termination_ctrl_out} == 45'h0 && !o_receivers_enabled;
    endsequence
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_reset_low: assert property (!i_reset_n |-> s_quiet)
        else $error("outputs not cleared under reset");
    a_wake_quiet: assert property ($rose(i_reset_n) |-> s_quiet [*6])
        else $error("output moved while receivers wake");
    a_hold_gated: assert property (live && gated |=> !i_reset_n ||
        ($stable(o_registered_outputs) && $stable(o_registered_outputs_b)
         && $stable(o_rank_select_out) && o_outputs_held))
        else $error("gated outputs changed");
    a_update_open: assert property (live && !gated |=> !i_reset_n ||
        (o_rank_select_out[0] == $past(i_primary_rank_select_in) && !o_outputs_held))
        else $error("open select did not update");
    a_ctrl_live: assert property (live |=> !i_reset_n ||
        (o_clock_enable_out[0] == $past(i_clock_enable_in)
         && o_termination_ctrl_out[0] == $past(i_termination_ctrl_in)))
        else $error("clock enable or termination frozen");
    a_wide_map: assert property (live && !gated && !i_fanout_mode_select
        |=> !i_reset_n ||
        (o_registered_outputs == ($past(i_buffered_inputs) & ~CRB_CTRL_MASK_WIDE)
         && o_registered_outputs_b == 14'h0000 && !o_clock_enable_out[1]))
        else $error("one-to-one image wrong");
    a_variant_map: assert property (live && !gated && i_fanout_mode_select |=> !i_reset_n ||
        o_registered_outputs[13:0] == ($past(i_buffered_inputs[13:0])
        & ~(i_pinout_variant_select ? CRB_CTRL_MASK_B : CRB_CTRL_MASK_A)))
        else $error("variant image wrong");
    a_copy_pair: assert property (i_fanout_mode_select |->
        o_registered_outputs[13:0] == o_registered_outputs_b
        && o_registered_outputs[24:14] == 11'h000
        && o_rank_select_out[1] == o_rank_select_out[0]
        && o_clock_enable_out[1] == o_clock_enable_out[0])
        else $error("copies A and B differ");
endmodule
bind crb_buffer_top crb_buffer_checker crb_buffer_checker_i (.i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst), .i_reset_n(i_reset_n),
    .i_pinout_variant_select(i_pinout_variant_select),
    .i_fanout_mode_select(i_fanout_mode_select), .i_buffered_inputs(i_buffered_inputs),
    .i_primary_rank_select_in(i_primary_rank_select_in),
    .i_secondary_rank_select_in(i_secondary_rank_select_in),
    .i_clock_enable_in(i_clock_enable_in), .i_termination_ctrl_in(i_termination_ctrl_in),
    .o_registered_outputs(o_registered_outputs),
    .o_registered_outputs_b(o_registered_outputs_b), .o_rank_select_out(o_rank_select_out),
    .o_clock_enable_out(o_clock_enable_out), .o_termination_ctrl_out(o_termination_ctrl_out),
    .o_receivers_enabled(o_receivers_enabled), .o_outputs_held(o_outputs_held));
`default_nettype wire

/* File: verif/test_crb_buffer_top.sv */
// Self-checking bench for the buffer top, all three configurations.
// Assumes the host model relays pin levels with no delay.
`timescale 1ns/10ps
`default_nettype none
module test_crb_buffer_top;
    import crb_pkg::*;
    typedef struct packed {
        logic [24:0] d;
        logic p;
        logic s;
        logic k;
        logic t;
    } crb_row_t;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic req_rst_n = 1'b0;
    logic mode_sel = 1'b0;
    logic var_sel = 1'b0;
    crb_row_t req = '0;
    wire logic rst_n;
    wire logic [28:0] pins;
    logic [24:0] q;
    logic [13:0] qb;
    logic [1:0] rank_select_out, clock_enable_out, termination_ctrl_out;
    logic rx_on, held;
    int n_fail = 0;
    int n_tests = 0;
    // Back-to-back rows; rows 2 and 3 are frozen, row 1 has only the secondary low
    crb_row_t rows [6] = '{'{25'h1FFFFFF, 1'b0, 1'b0, 1'b1, 1'b1},
        '{25'h0AAAAAA, 1'b1, 1'b0, 1'b0, 1'b1}, '{25'h1555555, 1'b1, 1'b1, 1'b1, 1'b0},
        '{25'h0000000, 1'b1, 1'b1, 1'b0, 1'b0}, '{25'h1234567, 1'b0, 1'b1, 1'b1, 1'b1},
        '{25'h0000000, 1'b0, 1'b0, 1'b0, 1'b0}};
    always #5 clk_sys = ~clk_sys;
    crb_host_model crb_host_model_i (.i_clk_sys(clk_sys), .i_req_reset_n(req_rst_n),
        .i_req(req), .o_reset_n(rst_n), .o_pins(pins));
    crb_buffer_top crb_buffer_top_i (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst),
        .i_reset_n(rst_n), .i_pinout_variant_select(var_sel),
        .i_fanout_mode_select(mode_sel), .i_buffered_inputs(pins[28:4]),
        .i_primary_rank_select_in(pins[3]), .i_secondary_rank_select_in(pins[2]),
        .i_clock_enable_in(pins[1]), .i_termination_ctrl_in(pins[0]),
        .o_registered_outputs(q), .o_registered_outputs_b(qb), .o_rank_select_out(rank_select_out),
        .o_clock_enable_out(clock_enable_out), .o_termination_ctrl_out(termination_ctrl_out),
        .o_receivers_enabled(rx_on), .o_outputs_held(held));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Config moves only under reset, so no live capture sees a half-synced mode
    task automatic restart(input logic m, input logic v);
        int i;
        req_rst_n = 1'b0;
        req = '0;
        mode_sel = m;
        var_sel = v;
        repeat (3) @(posedge clk_sys);
        #1;
        check(64'({q, qb, rank_select_out, clock_enable_out, termination_ctrl_out, rx_on}), 64'h0);
        req_rst_n = 1'b1;
        for (i = 0; i < 20 && rx_on !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
            check(64'({q, qb, rank_select_out, clock_enable_out, termination_ctrl_out}), 64'h0);
        end
        if (rx_on !== 1'b1) begin
            n_fail++;
            complete_run();
        end
    endtask
    // One row a cycle; frozen rows keep the last open image
    task automatic run_rows(input logic m, input logic v);
        logic [24:0] ev;
        logic [13:0] eb;
        logic [1:0] er;
        logic [13:0] mk;
        logic [45:0] ex;
        ev = '0;
        eb = '0;
        er = '0;
        mk = v ? CRB_CTRL_MASK_B : CRB_CTRL_MASK_A;
        foreach (rows[j]) begin
            req = rows[j];
            @(posedge clk_sys);
            #1;
            if (!(rows[j].p && rows[j].s)) begin
                ev = m ? {11'h000, rows[j].d[13:0] & ~mk} : rows[j].d & ~CRB_CTRL_MASK_WIDE;
                eb = m ? ev[13:0] : 14'h0000;
                er = {m & rows[j].p, rows[j].p};
            end
            // Control pairs follow every row; held flags a frozen capture
            ex = {ev, eb, er, m & rows[j].k, rows[j].k,
                m & rows[j].t, rows[j].t, rows[j].p & rows[j].s};
            check(64'({q, qb, rank_select_out, clock_enable_out, termination_ctrl_out, held}), 64'(ex));
        end
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int c;
        repeat (4) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        for (c = 0; c < 3; c++) begin
            restart(c != 0, c == 2);
            run_rows(c != 0, c == 2);
        end
        // Reset pin drops mid-cycle while outputs are frozen high
        req = rows[0];
        @(posedge clk_sys);
        #1;
        req = rows[2];
        @(posedge clk_sys);
        #1;
        check(64'(held), 64'h1);
        // Pin drops between edges, so only the async clear can empty the outputs
        req_rst_n = 1'b0;
        #1;
        check(64'({q, qb, rank_select_out, clock_enable_out, termination_ctrl_out, rx_on}), 64'h0);
        complete_run();
    end
endmodule
`default_nettype wire
